// ### llp_pkg.sv
// Purpose: Shared constants for the line-locked pixel clock generator.
// Assumes: 32-bit register port, one aligned word per register.
// Notes: Offsets, field positions, reset values and loop scaling live here.
package llp_pkg;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] LLP_OFS_DIVIDER = 8'h00;
	localparam logic [7:0] LLP_OFS_NOM_LO = 8'h04;
	localparam logic [7:0] LLP_OFS_NOM_HI = 8'h08;
	localparam logic [7:0] LLP_OFS_CTRL = 8'h0c;
	localparam logic [7:0] LLP_OFS_GATE = 8'h10;
	localparam logic [7:0] LLP_OFS_WORK_LO = 8'h14;
	localparam logic [7:0] LLP_OFS_WORK_HI = 8'h18;
	localparam logic [7:0] LLP_OFS_STATUS = 8'h1c;

	// ************************************************************
	// Control and gate register fields
	// ************************************************************
	localparam int LLP_CTRL_DET_OFF = 0;
	localparam int LLP_CTRL_POL = 1;
	localparam int LLP_CTRL_SEL_EXT = 2;
	localparam int LLP_CTRL_OUT_DIV = 3;
	localparam int LLP_CTRL_HGATE = 4;
	localparam int LLP_CTRL_VGATE = 5;
	localparam int LLP_CTRL_GP_LSB = 8;
	localparam int LLP_CTRL_GI_LSB = 12;
	localparam int LLP_CTRL_MULT_LSB = 16;
	localparam int LLP_CTRL_PHASE_LSB = 24;
	localparam int LLP_GATE_H_LSB = 0;
	localparam int LLP_GATE_V_LSB = 8;
	localparam int LLP_GATE_THR_LSB = 16;

	// ************************************************************
	// Widths, reset values and loop scaling
	// ************************************************************
	localparam int LLP_INC_W = 33;
	localparam int LLP_INT_W = 6;
	localparam int LLP_FRAC_W = 27;
	localparam int LLP_ACC_W = 34;
	localparam int LLP_DIV_W = 12;
	localparam int LLP_ERR_W = 13;
	localparam int LLP_PHASE_STEPS = 31;
	localparam int LLP_GAIN_BASE = 4;
	localparam logic [11:0] LLP_RST_DIVIDER = 12'h520;
	localparam logic [32:0] LLP_RST_NOMINAL = 33'h0ba2e8a16;
	localparam logic [3:0] LLP_RST_MULT = 4'h8;
	localparam logic [7:0] LLP_RST_MIN_WIDTH = 8'h04;
	localparam logic [7:0] LLP_RST_LOCK_THR = 8'h02;
	localparam logic [2:0] LLP_RST_GAIN = 3'h2;

endpackage : llp_pkg

// ### llp_gate_if.sv
// Purpose: Carrier between the top block and one sync noise gate.
// Assumes: All signals on the block clock.
// Notes: The top drives level, enable and width; the gate drives valid.
`timescale 1ns/100ps
interface llp_gate_if;
	logic level;
	logic enable;
	logic [7:0] min_width;
	logic valid;
	modport gate (input level, input enable, input min_width, output valid);
	modport ctl (output level, output enable, output min_width, input valid);
endinterface : llp_gate_if

// ### llp_noise_gate.sv
// Purpose: Sync noise gate that passes a pulse once it has lasted long enough.
// Assumes: Input level is already synchronised and polarity corrected.
// Notes: With the gate off the level passes after one register stage.
`timescale 1ns/100ps
module llp_noise_gate
	import llp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	llp_gate_if.gate gi
);

	typedef struct packed {
		logic [7:0] run;
		logic valid;
	} llp_gate_state_t;

	llp_gate_state_t q;
	llp_gate_state_t d;

	always_comb
	begin
		d = q;
		if (!gi.level)
		begin
			d.run = 8'h00;
			d.valid = 1'b0;
		end
		else if (!gi.enable)
		begin
			d.valid = 1'b1;
		end
		else
		begin
			// Saturate so that a long pulse cannot wrap and drop valid.
			if (q.run != 8'hff)
				d.run = q.run + 8'h01;
			if (d.run >= gi.min_width)
				d.valid = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign gi.valid = q.valid;

endmodule : llp_noise_gate

// ### llp_pixel_pll.sv
// Purpose: Digital line-locked pixel clock generator with register port.
// Assumes: clk stands for the internal high-speed clock (master x factor).
// Notes: Sync, freeze and external clock pins are synchronised on entry.
`timescale 1ns/100ps
module llp_pixel_pll
	import llp_pkg::*;
#(
	parameter int PHASE_TAPS = 32
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	input wire logic freeze_input,
	input wire logic external_pixel_clock_in,
	output logic converter_clock,
	output logic output_data_clock,
	output logic pll_clock_out,
	output logic lock,
	output logic line_sync_valid,
	output logic frame_sync_valid
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (PHASE_TAPS < LLP_PHASE_STEPS || PHASE_TAPS > 64)
	begin : g_bad_taps
		$error("PHASE_TAPS must lie between the step count and 64");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic hs1;
		logic hs2;
		logic vs1;
		logic vs2;
		logic fz1;
		logic fz2;
		logic xc1;
		logic xc2;
		logic [11:0] divider;
		logic [32:0] nominal;
		logic detector_off;
		logic line_sync_polarity;
		logic sample_clock_select;
		logic out_div_en;
		logic hgate_en;
		logic vgate_en;
		logic [2:0] gain_p;
		logic [2:0] gain_i;
		logic [3:0] analog_mult_factor;
		logic [4:0] phase;
		logic [7:0] line_sync_min_width;
		logic [7:0] frame_sync_min_width;
		logic [7:0] lock_hysteresis_threshold;
		logic [LLP_ACC_W-1:0] acc;
		logic pix;
		logic pixdiv;
		logic [PHASE_TAPS-1:0] hist;
		logic conv;
		logic dclk;
		logic pll_out;
		logic [11:0] fbcnt;
		logic hs_prev;
		logic hs_val;
		logic vs_val;
		logic signed [LLP_ERR_W-1:0] err;
		logic signed [LLP_ACC_W-1:0] integ;
		logic [32:0] working_increment;
		logic lock;
		logic [31:0] rdata;
	} llp_state_t;

	llp_state_t q;
	llp_state_t d;

	llp_gate_if hs_gate ();
	llp_gate_if vs_gate ();

	llp_noise_gate u_hs_gate (
		.clk(clk),
		.rst_n(rst_n),
		.gi(hs_gate)
	);

	llp_noise_gate u_vs_gate (
		.clk(clk),
		.rst_n(rst_n),
		.gi(vs_gate)
	);

	// Polarity 1 means active high; the gate always sees active high.
	assign hs_gate.level = q.line_sync_polarity ? q.hs2 : ~q.hs2;
	assign hs_gate.enable = q.hgate_en;
	assign hs_gate.min_width = q.line_sync_min_width;
	assign vs_gate.level = q.vs2;
	assign vs_gate.enable = q.vgate_en;
	assign vs_gate.min_width = q.frame_sync_min_width;

	function automatic logic [LLP_ERR_W-1:0] llp_abs(
		input logic signed [LLP_ERR_W-1:0] v
	);
		llp_abs = v[LLP_ERR_W-1] ? LLP_ERR_W'(-v) : LLP_ERR_W'(v);
	endfunction : llp_abs

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		logic hs_rise;
		logic div_rise;
		logic phased;
		logic [LLP_ERR_W-1:0] mag;
		logic signed [LLP_ERR_W-1:0] e;
		logic signed [LLP_ACC_W-1:0] e_ext;
		logic signed [LLP_ACC_W-1:0] prop;
		logic signed [LLP_ACC_W-1:0] integ;
		logic signed [LLP_ACC_W-1:0] sum;
		hs_rise = 1'b0;
		div_rise = 1'b0;
		phased = 1'b0;
		mag = '0;
		e = '0;
		e_ext = '0;
		prop = '0;
		integ = '0;
		sum = '0;
		d = q;

		d.hs1 = line_sync_in;
		d.hs2 = q.hs1;
		d.vs1 = frame_sync_in;
		d.vs2 = q.vs1;
		d.fz1 = freeze_input;
		d.fz2 = q.fz1;
		d.xc1 = external_pixel_clock_in;
		d.xc2 = q.xc1;
		d.hs_val = hs_gate.valid;
		d.vs_val = vs_gate.valid;

		// Register writes.
		if (wr_en)
		begin
			case (addr)
				LLP_OFS_DIVIDER: d.divider = wr_data[11:0];
				LLP_OFS_NOM_LO: d.nominal[31:0] = wr_data;
				LLP_OFS_NOM_HI: d.nominal[32] = wr_data[0];
				LLP_OFS_CTRL:
				begin
					d.detector_off = wr_data[LLP_CTRL_DET_OFF];
					d.line_sync_polarity = wr_data[LLP_CTRL_POL];
					d.sample_clock_select = wr_data[LLP_CTRL_SEL_EXT];
					d.out_div_en = wr_data[LLP_CTRL_OUT_DIV];
					d.hgate_en = wr_data[LLP_CTRL_HGATE];
					d.vgate_en = wr_data[LLP_CTRL_VGATE];
					d.gain_p = wr_data[LLP_CTRL_GP_LSB +: 3];
					d.gain_i = wr_data[LLP_CTRL_GI_LSB +: 3];
					d.analog_mult_factor = wr_data[LLP_CTRL_MULT_LSB +: 4];
					// Steps beyond the last one are clamped to it.
					if (wr_data[LLP_CTRL_PHASE_LSB +: 5] >= 5'(LLP_PHASE_STEPS))
						d.phase = 5'(LLP_PHASE_STEPS - 1);
					else
						d.phase = wr_data[LLP_CTRL_PHASE_LSB +: 5];
				end
				LLP_OFS_GATE:
				begin
					d.line_sync_min_width = wr_data[LLP_GATE_H_LSB +: 8];
					d.frame_sync_min_width = wr_data[LLP_GATE_V_LSB +: 8];
					d.lock_hysteresis_threshold = wr_data[LLP_GATE_THR_LSB +: 8];
				end
				default: ;
			endcase
		end

		// Phase accumulator; its top bit is the raw pixel clock.
		d.acc = q.acc + LLP_ACC_W'(q.working_increment);
		d.pix = q.acc[LLP_ACC_W-1];
		if (q.out_div_en)
		begin
			if (q.acc[LLP_ACC_W-1] && !q.pix)
				d.pixdiv = ~q.pixdiv;
		end
		else
			d.pixdiv = q.pix;
		div_rise = d.pixdiv && !q.pixdiv;

		// Delay line gives the sampling phase in whole fast-clock steps.
		d.hist = {q.hist[PHASE_TAPS-2:0], q.pixdiv};
		phased = q.hist[q.phase];
		d.pll_out = phased;
		d.conv = q.sample_clock_select ? q.xc2 : phased;
		d.dclk = q.conv;

		// Feedback divider counts divided pixel clocks per line.
		if (div_rise)
		begin
			if (q.fbcnt >= q.divider - 12'h001)
				d.fbcnt = 12'h000;
			else
				d.fbcnt = q.fbcnt + 12'h001;
		end

		hs_rise = q.hs_val && !q.hs_prev;
		d.hs_prev = q.hs_val;

		// Error is where the divider stands when the line sync arrives.
		if (q.fbcnt < {1'b0, q.divider[11:1]})
			e = LLP_ERR_W'(q.fbcnt);
		else
			e = LLP_ERR_W'(q.fbcnt) - LLP_ERR_W'(q.divider);
		e_ext = LLP_ACC_W'(e);
		prop = e_ext <<< (LLP_GAIN_BASE + int'(q.gain_p));
		integ = q.integ + (e_ext <<< int'(q.gain_i));
		sum = $signed({1'b0, q.nominal}) - prop - integ;
		mag = llp_abs(e);

		if (q.detector_off)
		begin
			d.integ = '0;
			d.err = '0;
			d.lock = 1'b0;
			d.working_increment = q.nominal;
		end
		else if (q.fz2)
		begin
			// Sync edges are ignored and the increment is held.
			d.working_increment = q.working_increment;
		end
		else if (hs_rise)
		begin
			d.err = e;
			d.integ = integ;
			// A negative sum would run the oscillator backwards.
			if (sum[LLP_ACC_W-1])
				d.working_increment = '0;
			else
				d.working_increment = sum[32:0];
			// Lock on small error, drop only past twice the threshold.
			if (mag <= LLP_ERR_W'(q.lock_hysteresis_threshold))
				d.lock = 1'b1;
			else if (mag > LLP_ERR_W'({q.lock_hysteresis_threshold, 1'b0}))
				d.lock = 1'b0;
		end

		// Read data stand only in the cycle after the read strobe.
		d.rdata = 32'h0000_0000;
		if (rd_en)
		begin
			case (addr)
				LLP_OFS_DIVIDER: d.rdata = {20'h00000, q.divider};
				LLP_OFS_NOM_LO: d.rdata = q.nominal[31:0];
				LLP_OFS_NOM_HI: d.rdata = {31'h0, q.nominal[32]};
				LLP_OFS_CTRL:
				begin
					d.rdata[LLP_CTRL_DET_OFF] = q.detector_off;
					d.rdata[LLP_CTRL_POL] = q.line_sync_polarity;
					d.rdata[LLP_CTRL_SEL_EXT] = q.sample_clock_select;
					d.rdata[LLP_CTRL_OUT_DIV] = q.out_div_en;
					d.rdata[LLP_CTRL_HGATE] = q.hgate_en;
					d.rdata[LLP_CTRL_VGATE] = q.vgate_en;
					d.rdata[LLP_CTRL_GP_LSB +: 3] = q.gain_p;
					d.rdata[LLP_CTRL_GI_LSB +: 3] = q.gain_i;
					d.rdata[LLP_CTRL_MULT_LSB +: 4] = q.analog_mult_factor;
					d.rdata[LLP_CTRL_PHASE_LSB +: 5] = q.phase;
				end
				LLP_OFS_GATE:
					d.rdata = {8'h00, q.lock_hysteresis_threshold,
						q.frame_sync_min_width, q.line_sync_min_width};
				LLP_OFS_WORK_LO: d.rdata = q.working_increment[31:0];
				LLP_OFS_WORK_HI:
					d.rdata = {31'h0, q.working_increment[32]};
				LLP_OFS_STATUS:
					d.rdata = {29'h0, q.fz2, q.hs_val, q.lock};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.divider <= LLP_RST_DIVIDER;
			q.nominal <= LLP_RST_NOMINAL;
			q.working_increment <= LLP_RST_NOMINAL;
			q.line_sync_polarity <= 1'b1;
			q.gain_p <= LLP_RST_GAIN;
			q.gain_i <= LLP_RST_GAIN;
			q.analog_mult_factor <= LLP_RST_MULT;
			q.line_sync_min_width <= LLP_RST_MIN_WIDTH;
			q.frame_sync_min_width <= LLP_RST_MIN_WIDTH;
			q.lock_hysteresis_threshold <= LLP_RST_LOCK_THR;
		end
		else
			q <= d;
	end

	assign rd_data = q.rdata;
	assign converter_clock = q.conv;
	assign output_data_clock = q.dclk;
	assign pll_clock_out = q.pll_out;
	assign lock = q.lock;
	assign line_sync_valid = q.hs_val;
	assign frame_sync_valid = q.vs_val;

endmodule : llp_pixel_pll

// ### llp_pll_assertions.sv
// Purpose: Port-level checks for the line-locked pixel clock generator.
// Assumes: Control state is mirrored from register writes at the port.
// Notes: Helper counters saturate, so long runs cost nothing extra.
`timescale 1ns/100ps
module llp_pll_checker
	import llp_pkg::*;
#(
	parameter int PHASE_TAPS = 32
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	input wire logic frame_sync_in,
	input wire logic external_pixel_clock_in,
	input wire logic converter_clock,
	input wire logic output_data_clock,
	input wire logic pll_clock_out,
	input wire logic lock,
	input wire logic line_sync_valid,
	input wire logic frame_sync_valid
);
	// ************************************************************
	// Mirrors of control state and run counters
	// ************************************************************
	logic [2:0] ctrl_q;
	logic [2:0] prev_q;
	logic [7:0] wv_q;
	logic [7:0] fs_run_q;
	logic [3:0] age_q;
	logic [3:0] same_q;
	logic [3:0] ext_run_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= 3'h0;
			prev_q <= 3'h0;
			wv_q <= LLP_RST_MIN_WIDTH;
			fs_run_q <= 8'h00;
			age_q <= 4'h0;
			same_q <= 4'h0;
			ext_run_q <= 4'h0;
		end
		else
		begin
			prev_q <= {external_pixel_clock_in, pll_clock_out, frame_sync_in};
			age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
			if (wr_en && addr == LLP_OFS_CTRL)
			begin
				ctrl_q <= {wr_data[LLP_CTRL_VGATE], wr_data[LLP_CTRL_SEL_EXT],
					wr_data[LLP_CTRL_DET_OFF]};
				age_q <= 4'h0;
			end
			if (wr_en && addr == LLP_OFS_GATE)
				wv_q <= wr_data[LLP_GATE_V_LSB +: 8];
			// A run length is kept after the pin falls, because the gate
			// output rises a few cycles behind the pin.
			if (frame_sync_in)
				fs_run_q <= !prev_q[0] ? 8'h01 :
					(fs_run_q == 8'hff ? fs_run_q : fs_run_q + 8'h01);
			same_q <= (pll_clock_out != prev_q[1]) ? 4'h0 :
				(same_q == 4'hf ? same_q : same_q + 4'h1);
			ext_run_q <= (external_pixel_clock_in != prev_q[2]) ? 4'h0 :
				(ext_run_q == 4'hf ? ext_run_q : ext_run_q + 4'h1);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ************************************************************
	// Properties
	// ************************************************************
	a_rd_quiet: assert property (!rd_en |=> rd_data == 32'h0)
		else $error("read data outside its slot");
	a_work_hi: assert property (rd_en && addr == LLP_OFS_WORK_HI
		|=> rd_data[31:1] == 31'h0)
		else $error("working high word wider than one bit");
	a_data_lag: assert property (
		output_data_clock == $past(converter_clock))
		else $error("data clock not one cycle behind converter clock");
	// The pin is compared one sample late, because the run counter still
	// shows the old run in the cycle in which the pin has just moved.
	a_ext_route: assert property (ctrl_q[1] && age_q == 4'hf
		&& ext_run_q >= 4'h8 |-> converter_clock == prev_q[2])
		else $error("converter clock does not follow external clock");
	a_loop_alive: assert property (ctrl_q[1:0] == 2'b11
		&& age_q == 4'hf |-> same_q < 4'h8)
		else $error("oscillator stopped with external clock selected");
	a_off_unlock: assert property (ctrl_q[0]
		&& age_q >= 4'h3 |-> !lock)
		else $error("lock high with detector off");
	a_lock_cause: assert property ($changed(lock) |-> ctrl_q[0]
		|| $past(ctrl_q[0])
		|| ($past(line_sync_valid) && !$past(line_sync_valid, 2)))
		else $error("lock changed without a line edge");
	a_gate_width: assert property ($rose(frame_sync_valid)
		&& ctrl_q[2] && age_q == 4'hf |-> fs_run_q >= wv_q)
		else $error("frame sync passed a short pulse");
	c_lock: cover property ($rose(lock));
	c_ext: cover property (ctrl_q[1] && converter_clock);
	c_gate: cover property ($rose(frame_sync_valid) && ctrl_q[2]);
endmodule : llp_pll_checker
bind llp_pixel_pll llp_pll_checker #(.PHASE_TAPS(PHASE_TAPS)) llp_pll_checker_inst (
	.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
	.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.frame_sync_in(frame_sync_in),
	.external_pixel_clock_in(external_pixel_clock_in),
	.converter_clock(converter_clock), .output_data_clock(output_data_clock),
	.pll_clock_out(pll_clock_out), .lock(lock),
	.line_sync_valid(line_sync_valid), .frame_sync_valid(frame_sync_valid));

// ### llp_sync_source.sv
// Purpose: Model of the video source feeding line sync and freeze.
// Assumes: One line lasts period clocks; width 0 sends no pulse.
// Notes: Freeze follows hold only at a line start, as a controller would.
`timescale 1ns/100ps
module llp_sync_source
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] period,
	input wire logic [7:0] width,
	input wire logic active_high,
	input wire logic hold,
	output logic line_sync,
	output logic freeze
);
	// ************************************************************
	// Line timing
	// ************************************************************
	logic [11:0] cnt_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 12'h000;
			line_sync <= 1'b0;
			freeze <= 1'b0;
		end
		else
		begin
			cnt_q <= (cnt_q + 12'h001 >= period) ? 12'h000 : cnt_q + 12'h001;
			line_sync <= active_high == ({4'h0, width} > cnt_q);
			if (cnt_q == 12'h000)
				freeze <= hold;
		end
	end
endmodule : llp_sync_source

// ### tb_llp_pixel_pll.sv
// Purpose: Self-checking bench for the line-locked pixel clock generator.
// Assumes: clk stands for master clock times eight, under the ceiling.
// Notes: Loop results are judged by a move away from nominal, not exact values.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_llp_pixel_pll
	import llp_pkg::*;
();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic frame_sync_in = 1'b0;
	logic external_pixel_clock_in = 1'b0;
	logic [11:0] period = 12'h000;
	logic [7:0] width = 8'h00;
	logic pol_hi = 1'b1;
	logic hold = 1'b0;
	logic [31:0] rd_data;
	logic line_sync_in, freeze_input, converter_clock, output_data_clock;
	logic pll_clock_out, lock, line_sync_valid, frame_sync_valid;
	int n_tests = 0;
	int miscompares = 0;
	always #5 clk = ~clk;
	llp_sync_source llp_sync_source_inst (.clk(clk), .rst_n(rst_n),
		.period(period), .width(width), .active_high(pol_hi), .hold(hold),
		.line_sync(line_sync_in), .freeze(freeze_input));
	llp_pixel_pll llp_pixel_pll_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
		.freeze_input(freeze_input),
		.external_pixel_clock_in(external_pixel_clock_in),
		.converter_clock(converter_clock),
		.output_data_clock(output_data_clock), .pll_clock_out(pll_clock_out),
		.lock(lock), .line_sync_valid(line_sync_valid),
		.frame_sync_valid(frame_sync_valid));
	// ************************************************************
	// Bus tasks and helpers
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	function automatic logic [31:0] ctl(input logic pol, input logic off,
		input logic ext, input logic vg);
		ctl = 32'h00082200;
		ctl[LLP_CTRL_DET_OFF] = off;
		ctl[LLP_CTRL_POL] = pol;
		ctl[LLP_CTRL_SEL_EXT] = ext;
		ctl[LLP_CTRL_VGATE] = vg;
	endfunction : ctl
	task automatic results();
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_defaults();
		logic [31:0] d;
		rd(LLP_OFS_DIVIDER, d);
		`CHK("divider", 32'h00000520, d)
		rd(LLP_OFS_NOM_LO, d);
		`CHK("nominal lo", LLP_RST_NOMINAL[31:0], d)
		rd(LLP_OFS_NOM_HI, d);
		`CHK("nominal hi", {31'h0, LLP_RST_NOMINAL[32]}, d)
		rd(LLP_OFS_WORK_LO, d);
		`CHK("working lo", LLP_RST_NOMINAL[31:0], d)
		rd(LLP_OFS_CTRL, d);
		`CHK("control", 32'h00082202, d)
		rd(8'h20, d);
		`CHK("unmapped", 32'h0, d)
		wr(LLP_OFS_DIVIDER, 32'hfffff010);
		rd(LLP_OFS_DIVIDER, d);
		`CHK("divider width", 32'h00000010, d)
		wr(LLP_OFS_CTRL, 32'h1f082202);
		rd(LLP_OFS_CTRL, d);
		`CHK("phase clamp", 32'h1e082202, d)
	endtask : t_defaults
	task automatic t_polarity();
		logic [7:0] cnt;
		for (int p = 0; p < 2; p++)
		begin
			wr(LLP_OFS_CTRL, ctl(p[0], 1'b1, 1'b0, 1'b0));
			pol_hi <= p[0];
			width <= 8'h06;
			period <= 12'h064;
			repeat (250) @(posedge clk);
			cnt = 8'h00;
			repeat (100) @(negedge clk) cnt += {7'h0, line_sync_valid};
			`CHK("line pulse", 8'h06, cnt)
		end
	endtask : t_polarity
	task automatic t_gate();
		logic [7:0] cnt;
		wr(LLP_OFS_GATE, 32'h00020404);
		wr(LLP_OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b1));
		repeat (16) @(posedge clk);
		for (int n = 3; n < 5; n++)
		begin
			cnt = 8'h00;
			for (int i = 0; i < 20; i++)
			begin
				@(posedge clk);
				frame_sync_in <= (i < n);
				@(negedge clk);
				cnt += {7'h0, frame_sync_valid};
			end
			`CHK("frame pulse", (n == 4), (cnt != 8'h00))
		end
	endtask : t_gate
	task automatic t_open_loop();
		logic [31:0] d;
		logic p;
		logic [4:0] n;
		wr(LLP_OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0));
		wr(LLP_OFS_NOM_LO, 32'h0);
		wr(LLP_OFS_NOM_HI, 32'h1);
		repeat (300) @(posedge clk);
		rd(LLP_OFS_WORK_LO, d);
		`CHK("open lo", 32'h0, d)
		rd(LLP_OFS_WORK_HI, d);
		`CHK("open hi", 32'h1, d)
		rd(LLP_OFS_STATUS, d);
		`CHK("open lock", 1'b0, d[0])
		`CHK("lock pin", 1'b0, lock)
		// An increment of a quarter turn gives a four-cycle raw clock, so
		// the extra divider must stretch it to eight cycles.
		wr(LLP_OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0) | 32'h00000008);
		repeat (50) @(posedge clk);
		@(negedge clk) p = pll_clock_out;
		n = 5'h00;
		repeat (16) @(negedge clk)
		begin
			n += {4'h0, pll_clock_out ^ p};
			p = pll_clock_out;
		end
		`CHK("out divider", 5'h04, n)
	endtask : t_open_loop
	task automatic t_ext();
		logic [2:0] s;
		wr(LLP_OFS_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'b0));
		repeat (16) @(posedge clk);
		for (int v = 1; v >= 0; v--)
		begin
			external_pixel_clock_in <= v[0];
			repeat (12) @(posedge clk);
			@(negedge clk);
			`CHK("external route", v[0], converter_clock)
		end
		s = 3'h0;
		repeat (5) @(negedge clk) s += {2'h0, pll_clock_out};
		`CHK("loop runs", 1'b1, (s != 3'h0 && s != 3'h5))
	endtask : t_ext
	task automatic t_closed();
		logic [31:0] lo, hi, w1;
		wr(LLP_OFS_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0));
		repeat (500) @(posedge clk);
		rd(LLP_OFS_WORK_LO, lo);
		rd(LLP_OFS_WORK_HI, hi);
		`CHK("loop acts", 1'b1, ({hi[0], lo} != 33'h100000000))
		hold <= 1'b1;
		repeat (250) @(posedge clk);
		rd(LLP_OFS_WORK_LO, w1);
		repeat (400) @(posedge clk);
		rd(LLP_OFS_WORK_LO, lo);
		`CHK("frozen", w1, lo)
		rd(LLP_OFS_STATUS, w1);
		`CHK("freeze seen", 1'b1, w1[2])
		hold <= 1'b0;
	endtask : t_closed
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
		t_polarity();
		t_gate();
		t_open_loop();
		t_ext();
		t_closed();
		results();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule : tb_llp_pixel_pll
